/* File: src/gdi_pkg.sv */
// Purpose: shared constants and types for the bus device port
// Assumes: 20 MHz clk, bus lines already synchronised
// Notes:   bus lines are true-high here; the pads invert them
package gdi_pkg;
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam logic [4:0]  ADDR_DEFAULT = 5'h08;
  localparam logic [4:0]  ADDR_MIN     = 5'h01;
  localparam logic [4:0]  ADDR_MAX     = 5'h1E;
  localparam int unsigned BUF_DEPTH    = 256;
  localparam int unsigned BUF_WIDTH    = 8;
  // interface command bytes, seen while attention is asserted
  localparam logic [1:0]  GRP_LISTEN   = 2'h1;
  localparam logic [1:0]  GRP_TALK     = 2'h2;
  localparam logic [4:0]  ADDR_UNADDR  = 5'h1F;
  localparam logic [6:0]  CMD_DCL      = 7'h14;
  localparam logic [6:0]  CMD_SDC      = 7'h04;
  localparam logic [6:0]  CMD_SPE      = 7'h18;
  localparam logic [6:0]  CMD_SPD      = 7'h19;
  localparam logic [6:0]  CMD_LLO      = 7'h11;
  localparam logic [6:0]  CMD_GET      = 7'h08;
  localparam int unsigned RQS_BIT      = 6;
  typedef enum logic [1:0] {GDI_SRC_IDLE, GDI_SRC_WAIT_NRFD, GDI_SRC_WAIT_NDAC} gdi_src_t;
  typedef enum logic [1:0] {GDI_ACC_READY, GDI_ACC_HOLD, GDI_ACC_WAIT_DROP} gdi_acc_t;
endpackage

/* File: src/gdi_fifo_if.sv */
// Purpose: valid/ready carrier between the port and its message buffer
// Assumes: one clock
// Notes:   src fills, dst drains
`timescale 1ns/100ps
interface gdi_fifo_if #(parameter int W = 8);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  logic         flush;
  modport fifo (input in_valid, in_data, out_ready, flush, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, flush, input in_ready, out_valid, out_data);
endinterface

/* File: src/gdi_fifo.sv */
// Purpose: message text buffer, width and depth set by parameters
// Assumes: synchronous reset, single clock
// Notes:   flush empties it in one cycle; data output is read straight from memory at the read pointer
`timescale 1ns/100ps
module gdi_fifo #(
  parameter int W = 8,
  parameter int D = 256
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // stream
  gdi_fifo_if.fifo  f
);
  localparam int AW = $clog2(D);
  initial if (D < 2 || (D & (D - 1)) != 0) $error("depth must be a power of two");

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } gdi_fst_t;
  gdi_fst_t s_q, s_d;
  logic [W-1:0] mem [D];
  logic         push, pop;

  assign f.in_ready  = (s_q.cnt != D[AW:0]);
  assign f.out_valid = (s_q.cnt != '0);
  assign f.out_data  = mem[s_q.rp];
  assign push = f.in_valid && f.in_ready;
  assign pop  = f.out_valid && f.out_ready;

  always_comb begin
    s_d = s_q;
    if (f.flush) begin
      s_d = '0;
    end else begin
      if (push) s_d.wp = s_q.wp + 1'b1;
      if (pop)  s_d.rp = s_q.rp + 1'b1;
      s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) s_q <= '0;
    else         s_q <= s_d;
    if (push)    mem[s_q.wp] <= f.in_data;
  end

  a_fifo_bound: assert property (@(posedge clk) disable iff (sys_rst) s_q.cnt <= D[AW:0])
    else $error("buffer count beyond capacity");
endmodule

/* File: src/gdi_device.sv */
// Purpose: device end of the instrument's parallel instrument bus
// Assumes: bus lines synchronous to clk, true-high, open-collector pads outside
// Notes:   talker, listener, handshakes, service request, device clear
`timescale 1ns/100ps
module gdi_device
  import gdi_pkg::*;
#(
  parameter int BUF_D = gdi_pkg::BUF_DEPTH
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // front panel
  input  wire logic       key_remote,
  input  wire logic       addr_wr,
  input  wire logic [4:0] addr_new,
  output logic      [4:0] addr_cur,
  output logic            panel_enable,
  // bus lines in
  input  wire logic [7:0] dio_in,
  input  wire logic       dav_in,
  input  wire logic       nrfd_in,
  input  wire logic       ndac_in,
  input  wire logic       atn_in,
  input  wire logic       ifc_in,
  // bus lines out, enable low while driving
  output logic      [7:0] dio_out,
  output logic            dio_oe_n,
  output logic            dav_out,
  output logic            dav_oe_n,
  output logic            nrfd_out,
  output logic            nrfd_oe_n,
  output logic            ndac_out,
  output logic            ndac_oe_n,
  output logic            atn_oe_n,
  output logic            srq_out,
  output logic            srq_oe_n,
  // received text to the command parser
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  // reply text and status from the instrument
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] status_byte,
  input  wire logic       srq_req,
  output logic            dev_clear
);
  initial if (BUF_D < 2) $error("buffer too small");

  typedef struct packed {
    logic [4:0] addr;
    logic       tacs;
    logic       lacs;
    logic       spms;
    logic       srq;
    logic       clr;
    gdi_src_t   src;
    logic [7:0] obyte;
    gdi_acc_t   acc;
    logic [7:0] ibyte;
    logic       push;
  } gdi_st_t;
  gdi_st_t s_q, s_d;

  gdi_fifo_if #(.W(BUF_WIDTH)) buf_if ();
  gdi_fifo #(.W(BUF_WIDTH), .D(BUF_D)) u_buf (
    .clk     (clk),
    .sys_rst (sys_rst),
    .f       (buf_if.fifo)
  );

  logic [4:0] cmd_addr;
  logic       is_cmd;
  logic       is_data;
  logic       my_listen;
  logic       my_talk;
  logic       acc_take;
  logic       send_ok;

  assign cmd_addr = dio_in[4:0];
  assign is_cmd   = atn_in;
  assign is_data  = !atn_in && s_q.lacs;
  // only the five primary address bits are compared
  assign my_listen = dio_in[6:5] == GRP_LISTEN && cmd_addr == s_q.addr;
  assign my_talk   = dio_in[6:5] == GRP_TALK   && cmd_addr == s_q.addr;
  // the acceptor only takes part while commands arrive or we are listening
  assign acc_take  = (is_cmd || is_data) && dav_in;
  assign send_ok   = s_q.tacs && !atn_in;

  always_comb begin
    s_d = s_q;
    s_d.push = 1'b0;
    s_d.clr  = 1'b0;
    s_d.srq  = srq_req;
    tx_ready = 1'b0;
    if (addr_wr && addr_new >= ADDR_MIN && addr_new <= ADDR_MAX) s_d.addr = addr_new;
    // acceptor handshake
    unique case (s_q.acc)
      GDI_ACC_READY: if (acc_take) begin
        s_d.ibyte = dio_in;
        s_d.acc   = GDI_ACC_HOLD;
        if (is_cmd) begin
          if (dio_in[6:0] == {GRP_LISTEN, ADDR_UNADDR}) s_d.lacs = 1'b0;
          else if (dio_in[6:5] == GRP_TALK && cmd_addr != s_q.addr) s_d.tacs = 1'b0;
          if (my_listen) begin
            s_d.lacs = 1'b1;
            s_d.tacs = 1'b0;
          end
          if (my_talk) begin
            s_d.tacs = 1'b1;
            s_d.lacs = 1'b0;
          end
          if (dio_in[6:0] == CMD_SPE) s_d.spms = 1'b1;
          if (dio_in[6:0] == CMD_SPD) s_d.spms = 1'b0;
          // clear from the bus is a command, so the key must be in remote
          if (key_remote && (dio_in[6:0] == CMD_DCL || (dio_in[6:0] == CMD_SDC && s_q.lacs))) s_d.clr = 1'b1;
          // lockout and trigger fall through unhandled
        end else begin
          s_d.push = key_remote;
        end
      end
      GDI_ACC_HOLD: if (!s_q.push || buf_if.in_ready) s_d.acc = GDI_ACC_WAIT_DROP;
      GDI_ACC_WAIT_DROP: if (!dav_in) s_d.acc = GDI_ACC_READY;
    endcase
    if (s_q.push && !buf_if.in_ready) s_d.push = 1'b1;
    // source handshake; status byte during serial poll, else reply text
    unique case (s_q.src)
      GDI_SRC_IDLE: if (send_ok && (s_q.spms || tx_valid)) begin
        s_d.obyte = s_q.spms ? status_byte : tx_data;
        if (s_q.spms) s_d.obyte[RQS_BIT] = s_q.srq;
        tx_ready  = !s_q.spms;
        s_d.src   = GDI_SRC_WAIT_NRFD;
        if (s_q.spms) s_d.srq = 1'b0;
      end
      GDI_SRC_WAIT_NRFD: begin
        if (!send_ok) s_d.src = GDI_SRC_IDLE;
        else if (!nrfd_in) s_d.src = GDI_SRC_WAIT_NDAC;
      end
      GDI_SRC_WAIT_NDAC: if (!ndac_in || !send_ok) s_d.src = GDI_SRC_IDLE;
    endcase
    if (ifc_in || s_q.clr) begin
      s_d.tacs = ifc_in ? 1'b0 : s_d.tacs;
      s_d.lacs = ifc_in ? 1'b0 : s_d.lacs;
      s_d.spms = 1'b0;
      s_d.src  = GDI_SRC_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q      <= '0;
      s_q.addr <= ADDR_DEFAULT;
    end else begin
      s_q <= s_d;
    end
  end

  assign buf_if.in_valid  = s_q.push;
  assign buf_if.in_data   = s_q.ibyte;
  assign buf_if.out_ready = rx_ready;
  assign buf_if.flush     = s_q.clr;
  assign rx_data  = buf_if.out_data;
  assign rx_valid = buf_if.out_valid;

  assign addr_cur     = s_q.addr;
  // only the key decides; a lockout command never reaches the panel
  assign panel_enable = !key_remote;
  assign dev_clear    = s_q.clr;
  assign dio_out   = s_q.obyte;
  // data lines only driven as addressed talker, serial poll included, never on a parallel poll
  // let go the moment attention rises, else our own data valid reads back as a command
  assign dio_oe_n  = !(s_q.src != GDI_SRC_IDLE && send_ok);
  assign dav_out   = s_q.src == GDI_SRC_WAIT_NDAC;
  assign dav_oe_n  = !(s_q.src != GDI_SRC_IDLE && send_ok);
  // nrfd held while busy or while the buffer cannot take a byte
  assign nrfd_out  = s_q.acc != GDI_ACC_READY || (is_data && !buf_if.in_ready);
  assign nrfd_oe_n = !(is_cmd || is_data);
  assign ndac_out  = !(s_q.acc == GDI_ACC_WAIT_DROP);
  assign ndac_oe_n = !(is_cmd || is_data);
  assign atn_oe_n  = 1'b1;
  assign srq_out   = s_q.srq;
  assign srq_oe_n  = !s_q.srq;

  a_talk_unlisten: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.acc == GDI_ACC_READY && dav_in && atn_in && my_listen |=> !s_q.tacs && s_q.lacs)
    else $error("talker kept after own listen address");
  a_listen_untalk: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.acc == GDI_ACC_READY && dav_in && atn_in && my_talk |=> !s_q.lacs && s_q.tacs)
    else $error("listener kept after own talk address");
  a_local_drops: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.acc == GDI_ACC_READY && dav_in && is_data && !key_remote |=> !s_q.push)
    else $error("bus text taken in local");
  a_srq_follow: assert property (@(posedge clk) disable iff (sys_rst)
    srq_req && s_q.src == GDI_SRC_IDLE && !(send_ok && s_q.spms) |=> srq_oe_n == 1'b0)
    else $error("service request not raised");
  a_no_atn: assert property (@(posedge clk) disable iff (sys_rst) atn_oe_n)
    else $error("attention driven");
  a_no_ppoll: assert property (@(posedge clk) disable iff (sys_rst)
    !dio_oe_n |-> s_q.tacs && !atn_in)
    else $error("data lines driven outside talk");
  a_addr_range: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.addr >= ADDR_MIN && s_q.addr <= ADDR_MAX)
    else $error("address out of range");
  a_addr_reset: assert property (@(posedge clk) $fell(sys_rst) |-> s_q.addr == ADDR_DEFAULT)
    else $error("address not default after reset");
  a_dav_seq: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(dav_out) |-> !$past(nrfd_in))
    else $error("data valid before ready");
  a_panel_lock: assert property (@(posedge clk) disable iff (sys_rst) key_remote |-> !panel_enable)
    else $error("panel live in remote");
endmodule

/* File: verif/gdi_ctrl_model.sv */
// Purpose: behavioural bus controller facing the device port
// Assumes: bench resolves bus levels, true-high
// Notes:   waits give up after LIM cycles so a stuck handshake shows as ok low
`timescale 1ns/100ps
module gdi_ctrl_model #(
  parameter int LIM = 200
) (
  // clock
  input  wire logic       clk,
  // resolved bus levels
  input  wire logic [7:0] dio_in,
  input  wire logic       dav_in,
  input  wire logic       nrfd_in,
  input  wire logic       ndac_in,
  // controller drive, 1 = asserted
  output logic            c_atn,
  output logic      [7:0] c_dio,
  output logic            c_dav,
  output logic            c_nrfd,
  output logic            c_ndac
);
  int n;
  initial begin
    c_atn = 1'b0;
    c_dio = 8'h00;
    c_dav = 1'b0;
    c_nrfd = 1'b0;
    c_ndac = 1'b0;
  end
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  // data settles one cycle before dav; released lines fall to the pull-up level
  task automatic send(input logic atn, input logic [7:0] d, output logic ok);
    step();
    c_atn = atn;
    c_dio = d;
    for (n = 0; n < LIM && nrfd_in !== 1'b0; n++) step();
    ok = (nrfd_in === 1'b0);
    step();
    c_dav = ok;
    for (n = 0; n < LIM && ok && ndac_in !== 1'b0; n++) step();
    ok = ok && (ndac_in === 1'b0);
    step();
    c_dav = 1'b0;
    c_dio = 8'h00;
  endtask
  // slow holds not-ready that many cycles before accepting
  task automatic recv(input int slow, output logic [7:0] d, output logic ok);
    step();
    c_atn = 1'b0;
    c_nrfd = (slow != 0);
    c_ndac = 1'b1;
    if (slow != 0) begin
      repeat (slow) step();
      c_nrfd = 1'b0;
    end
    for (n = 0; n < LIM && dav_in !== 1'b1; n++) step();
    ok = (dav_in === 1'b1);
    d = dio_in;
    step();
    c_nrfd = ok;
    c_ndac = 1'b0;
    for (n = 0; n < LIM && ok && dav_in !== 1'b0; n++) step();
    step();
    c_nrfd = 1'b0;
  endtask
endmodule

/* File: verif/gdi_device_test.sv */
// Purpose: self-checking bench for the bus device port
// Assumes: controller model on the far side, wired-or bus levels
// Notes:   address table first, then hand-written bus scenarios
`timescale 1ns/100ps
module gdi_device_test;
  import gdi_pkg::*;
  typedef struct packed {logic [4:0] a; logic [4:0] e;} gdi_row_t;
  localparam gdi_row_t ROWS [5] = '{'{5'h00, 5'h08}, '{5'h01, 5'h01}, '{5'h1E, 5'h1E}, '{5'h1F, 5'h1E}, '{5'h08, 5'h08}};
  logic       clk = 0, sys_rst = 1, key_remote = 1, addr_wr = 0, rx_ready = 0, tx_valid = 0, srq_req = 0, ifc_in = 0;
  logic [4:0] addr_new = 5'h00, addr_cur;
  logic [7:0] tx_data = 8'h00, status_byte = 8'h00, dio_in, dio_out, rx_data, c_dio, d;
  logic       dav_in, nrfd_in, ndac_in, atn_in, dio_oe_n, dav_out, dav_oe_n, nrfd_out, nrfd_oe_n, ndac_out, ndac_oe_n;
  logic       atn_oe_n, srq_out, srq_oe_n, rx_valid, tx_ready, dev_clear, panel_enable, c_atn, c_dav, c_nrfd, c_ndac;
  logic       ok, cleared, a1 = 0;
  int         miscompares = 0, tests_run = 0, n;
  always #25 clk = ~clk;
  assign atn_in  = c_atn;
  assign dio_in  = c_dio | (dio_oe_n ? 8'h00 : dio_out);
  assign dav_in  = c_dav | (~dav_oe_n & dav_out);
  assign nrfd_in = c_nrfd | (~nrfd_oe_n & nrfd_out);
  assign ndac_in = c_ndac | (~ndac_oe_n & ndac_out);
  gdi_device i_dut (.clk, .sys_rst, .key_remote, .addr_wr, .addr_new, .addr_cur, .panel_enable, .dio_in, .dav_in,
    .nrfd_in, .ndac_in, .atn_in, .ifc_in, .dio_out, .dio_oe_n, .dav_out, .dav_oe_n, .nrfd_out, .nrfd_oe_n, .ndac_out,
    .ndac_oe_n, .atn_oe_n, .srq_out, .srq_oe_n, .rx_data, .rx_valid, .rx_ready, .tx_data, .tx_valid, .tx_ready,
    .status_byte, .srq_req, .dev_clear);
  gdi_ctrl_model i_ctrl (.clk, .dio_in, .dav_in, .nrfd_in, .ndac_in, .c_atn, .c_dio, .c_dav, .c_nrfd, .c_ndac);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic pop(input logic [7:0] exp);
    for (n = 0; n < 20 && rx_valid !== 1'b1; n++) cyc(1);
    chk(rx_data, exp);
    rx_ready = 1;
    cyc(1);
    rx_ready = 0;
  endtask
  // reply byte is offered once; a pulse on tx_ready means it was taken
  always @(posedge clk) begin
    a1 <= c_atn;
    if (dev_clear === 1'b1) cleared = 1'b1;
    if (tx_ready === 1'b1) tx_valid <= 1'b0;
    if (a1 && c_atn) chk({atn_oe_n, dio_oe_n}, 2'b11);
  end
  initial begin
    #(50 * 20000);
    miscompares++;
    wrap_up();
  end
  initial begin
    cleared = 0;
    repeat (10) @(posedge clk);
    #1 sys_rst = 0;
    chk({addr_cur, atn_oe_n, panel_enable}, {ADDR_DEFAULT, 2'b10});
    foreach (ROWS[i]) begin
      addr_new = ROWS[i].a;
      addr_wr = 1;
      cyc(1);
      addr_wr = 0;
      cyc(1);
      chk(addr_cur, ROWS[i].e);
    end
    i_ctrl.send(1, {1'b0, GRP_LISTEN, ADDR_DEFAULT}, ok);
    i_ctrl.send(0, 8'h41, ok);
    i_ctrl.send(1, {1'b0, CMD_LLO}, ok);
    i_ctrl.send(1, {1'b0, CMD_GET}, ok);
    i_ctrl.send(0, 8'h42, ok);
    chk(cleared, 0);
    pop(8'h41);
    pop(8'h42);
    for (int i = 0; i < 257; i++) begin
      i_ctrl.send(0, i[7:0], ok);
      chk(ok, i < 256);
    end
    rx_ready = 1;
    n = 0;
    repeat (700) begin
      if (rx_valid === 1'b1) n++;
      cyc(1);
    end
    rx_ready = 0;
    chk(n, 256);
    i_ctrl.send(0, 8'h55, ok);
    i_ctrl.send(1, {1'b0, CMD_DCL}, ok);
    cyc(3);
    chk({cleared, rx_valid}, 2'b10);
    i_ctrl.send(1, {1'b0, GRP_TALK, ADDR_DEFAULT}, ok);
    i_ctrl.send(0, 8'h44, ok);
    cyc(3);
    chk(rx_valid, 0);
    tx_data = 8'h5A;
    tx_valid = 1;
    i_ctrl.recv(0, d, ok);
    chk({ok, d}, {1'b1, 8'h5A});
    i_ctrl.send(1, {1'b0, GRP_LISTEN, ADDR_DEFAULT}, ok);
    tx_valid = 1;
    i_ctrl.recv(0, d, ok);
    chk(ok, 0);
    tx_valid = 0;
    status_byte = 8'h11;
    srq_req = 1;
    cyc(3);
    chk({srq_oe_n, srq_out}, 2'b01);
    i_ctrl.send(1, {1'b0, CMD_SPE}, ok);
    i_ctrl.send(1, {1'b0, GRP_TALK, ADDR_DEFAULT}, ok);
    i_ctrl.recv(3, d, ok);
    chk(d, 8'h11 | (8'h01 << RQS_BIT));
    i_ctrl.send(1, {1'b0, CMD_SPD}, ok);
    srq_req = 0;
    key_remote = 0;
    cleared = 0;
    cyc(1);
    chk(panel_enable, 1);
    i_ctrl.send(1, {1'b0, GRP_LISTEN, ADDR_DEFAULT}, ok);
    i_ctrl.send(0, 8'h77, ok);
    i_ctrl.send(1, {1'b0, CMD_DCL}, ok);
    cyc(3);
    chk({ok, rx_valid, cleared}, 3'b100);
    key_remote = 1;
    i_ctrl.send(1, {1'b0, CMD_SDC}, ok);
    cyc(3);
    chk({ok, cleared}, 2'b11);
    i_ctrl.send(1, {1'b0, GRP_LISTEN, ADDR_UNADDR}, ok);
    i_ctrl.send(0, 8'h66, ok);
    cyc(3);
    chk(rx_valid, 0);
    i_ctrl.send(1, {1'b0, GRP_TALK, ADDR_DEFAULT}, ok);
    ifc_in = 1;
    cyc(1);
    ifc_in = 0;
    tx_valid = 1;
    i_ctrl.recv(0, d, ok);
    tx_valid = 0;
    chk(ok, 0);
    wrap_up();
  end
endmodule
